// ---- include/asr_pkg.sv ----
/*
 * Package for the scan result readout and input select block:
 * register offsets, field positions, reset values and carrier types.
 * Assumes a 32-bit register port with one aligned word per register.
 */
package asr_pkg;

    // ==========================================================
    // Register offsets (byte addresses)
    // ==========================================================
    localparam logic [7:0] OFS_SCAN_FIFO_CFG = 8'h80;
    localparam logic [7:0] OFS_SCAN_FIFO_POP_DATA = 8'h84;
    localparam logic [7:0] OFS_SCAN_FIFO_STATUS = 8'h88;
    localparam logic [7:0] OFS_SCAN_LATEST_RESULT = 8'h8C;
    localparam logic [7:0] OFS_IRQ_STATUS = 8'h90;
    localparam logic [7:0] OFS_IRQ_MASK = 8'h94;
    localparam logic [7:0] OFS_SINGLE_QUEUE_SEL = 8'h98;
    localparam logic [7:0] OFS_SCAN_ENTRY_BASE = 8'hA0;

    // ==========================================================
    // Field positions and reset values
    // ==========================================================
    localparam int ALIGN_LSB = 0;
    localparam int SHOW_ENTRY_IDENTIFIER_BIT = 3;
    localparam int CMP_BIT = 17;
    localparam int CFG_BIT = 16;
    localparam int ENTRY_W = 18;
    localparam logic [31:0] RST_ZERO = 32'h0000_0000;
    localparam logic [7:0] SHOWN_ID_NONE = 8'h00;
    localparam int IRQ_W = 3;
    localparam int IRQ_PUSH = 0;
    localparam int IRQ_OVFL = 1;
    localparam int IRQ_EMPTY_POP = 2;

    // Alignment codes
    typedef enum logic [2:0] {
        right_justify_12bit = 3'h0,
        right_justify_16bit = 3'h1,
        right_justify_20bit = 3'h2,
        left_justify_12bit = 3'h3,
        left_justify_16bit = 3'h4,
        left_justify_20bit = 3'h5
    } asr_align_t;

    // Positive port codes
    localparam logic [3:0] PORT_GND = 4'h0;
    localparam logic [3:0] PORT_SUPPLY = 4'h1;
    localparam logic [3:0] PORT_CONV_CH = 4'h2;
    localparam logic [3:0] PORT_ANALOG_PAD = 4'h4;
    localparam logic [3:0] PORT_IO_FIRST = 4'h8;
    localparam logic [3:0] PORT_IO_LAST = 4'hB;

    // Entry register layout, shared by single queue and scan entries
    typedef struct packed {
        logic window_compare_enable;
        logic settings_group_sel;
        logic [3:0] positive_port_select;
        logic [3:0] positive_pin_select;
        logic [3:0] negative_port_select;
        logic [3:0] negative_pin_select;
    } asr_entry_t;

    // Decoded multiplexer selection handed to the analog front end
    typedef struct packed {
        logic pos_ground;
        logic pos_supply;
        logic pos_conv_ch;
        logic pos_pad;
        logic pos_io;
        logic [1:0] pos_io_port;
        logic [3:0] pos_pin;
        logic neg_ground;
        logic neg_conv_ch;
        logic neg_pad;
        logic neg_io;
        logic [1:0] neg_io_port;
        logic [3:0] neg_pin;
        logic compare_en;
        logic settings_group;
    } asr_route_t;

    // Register bus request
    typedef struct packed {
        logic [7:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } asr_bus_t;

    // Conversion result from the engine
    typedef struct packed {
        logic [19:0] data;
        logic [7:0] id;
    } asr_result_t;

endpackage : asr_pkg

// ---- verification/asr_scan_block_tb_top.sv ----
/*
 * Self-checking testbench for the scan result readout and input select
 * block, with a queue-based reference model of the FIFO, status and irq.
 * Assumes the package constants and the one-cycle register port timing.
 */
`timescale 1ns/1ps

module asr_scan_block_tb_top
    import asr_pkg::*;
;
    localparam int DEPTH = 4;
    logic i_sys_clk, i_rst_n, i_clk_en, i_wr, i_rd, i_res_valid;
    logic [7:0] i_addr, i_res_id;
    logic [31:0] i_wdata, o_rdata, latest, rdv;
    logic [19:0] i_res_data;
    logic [3:0] i_scan_index;
    asr_route_t o_single_route, o_scan_route;
    logic o_fifo_overflow, o_irq, ovf, show;
    logic [2:0] st, mask;
    logic [31:0] q[$];
    logic [3:0] codes[8] = '{4'h0, 4'h1, 4'h2, 4'h4, 4'h8, 4'h9, 4'hA, 4'hB};
    logic [17:0] ent;
    logic [7:0] ea;
    int code, error_cnt, checked;

    asr_scan_block #(.DEPTH(DEPTH), .NUM_ENTRIES(16)) dut_u (
        .i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_clk_en(i_clk_en),
        .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
        .o_rdata(o_rdata), .i_res_valid(i_res_valid),
        .i_res_data(i_res_data), .i_res_id(i_res_id),
        .i_scan_index(i_scan_index), .o_single_route(o_single_route),
        .o_scan_route(o_scan_route), .o_fifo_overflow(o_fifo_overflow),
        .o_irq(o_irq));

    // ==========================================================
    // Clock and watchdog
    // ==========================================================
    initial
    begin
        i_sys_clk = 1'b0;
        forever #4 i_sys_clk = ~i_sys_clk;
    end

    // A hang counts as a mismatch and ends the run
    initial
    begin
        repeat (50000) @(posedge i_sys_clk);
        error_cnt++;
        print_verdict();
    end

    // ==========================================================
    // Checking and reporting
    // ==========================================================
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    task automatic print_verdict();
        $display("checked=%0d error_cnt=%0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : print_verdict

    // ==========================================================
    // Register port: one-cycle strobes, read data the cycle after
    // ==========================================================
    task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge i_sys_clk);
        i_wr <= 1'b1;
        i_addr <= a;
        i_wdata <= d;
        @(posedge i_sys_clk);
        i_wr <= 1'b0;
    endtask : bus_wr

    task automatic bus_rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge i_sys_clk);
        i_rd <= 1'b1;
        i_addr <= a;
        @(posedge i_sys_clk);
        i_rd <= 1'b0;
        #1;
        d = o_rdata;
    endtask : bus_rd

    // ==========================================================
    // Reference model
    // ==========================================================
    // Word layout per alignment code; identifier byte zero when hidden
    function automatic logic [31:0] fmt(input int c, input logic s,
        input logic [19:0] d, input logic [7:0] id);
        logic [7:0] i;
        logic [31:0] w;
        int n;
        i = s ? id : SHOWN_ID_NONE;
        n = 12 + 4 * (c % 3);
        w = '0;
        if (c < 3)
        begin
            w[31:24] = i;
            for (int b = 0; b < 24; b++)
                w[b] = (b < n) ? d[b] : d[n - 1];
        end
        else
        begin
            for (int b = 0; b < n; b++)
                w[32 - n + b] = d[b];
            w[7:0] = i;
        end
        return w;
    endfunction : fmt

    // Full FIFO or latched overflow drops the word, latest still moves
    task automatic push(input logic [19:0] d, input logic [7:0] id);
        @(posedge i_sys_clk);
        i_res_valid <= 1'b1;
        i_res_data <= d;
        i_res_id <= id;
        @(posedge i_sys_clk);
        i_res_valid <= 1'b0;
        latest = fmt(code, show, d, id);
        if (!ovf && q.size() < DEPTH)
        begin
            q.push_back(latest);
            st[0] = 1'b1;
        end
        else
        begin
            ovf = 1'b1;
            st[1] = 1'b1;
        end
    endtask : push

    task automatic pop();
        logic [31:0] exp;
        exp = '0;
        if (q.size() > 0)
        begin
            exp = q.pop_front();
            ovf = 1'b0;
        end
        else
            st[2] = 1'b1;
        bus_rd(OFS_SCAN_FIFO_POP_DATA, rdv);
        chk(rdv, exp);
    endtask : pop

    task automatic chk_state();
        bus_rd(OFS_SCAN_FIFO_STATUS, rdv);
        chk(rdv, 32'(q.size()));
        chk(32'(o_fifo_overflow), 32'(ovf));
        chk(32'(o_irq), 32'(|(st & mask)));
        bus_rd(OFS_SCAN_LATEST_RESULT, rdv);
        chk(rdv, latest);
    endtask : chk_state

    // Flags always; pin and port number only where the code uses them
    task automatic chk_route(input asr_route_t r, input logic [17:0] e);
        logic [3:0] p;
        logic [3:0] n;
        p = e[15:12];
        n = e[7:4];
        chk(32'({r.pos_ground, r.pos_supply, r.pos_conv_ch, r.pos_pad,
            r.pos_io}), 32'({p == 0, p == 1, p == 2, p == 4,
            p >= 8}));
        if (p == 4'h1 || p >= 4'h8)
            chk(32'(r.pos_pin), 32'(e[11:8]));
        if (p >= 4'h8)
            chk(32'(r.pos_io_port), 32'(p[1:0]));
        chk(32'({r.neg_ground, r.neg_conv_ch, r.neg_pad, r.neg_io}),
            32'({n == 0, n == 2, n == 4, n >= 8}));
        if (n >= 4'h8)
            chk(32'({r.neg_io_port, r.neg_pin}),
                32'({n[1:0], e[3:0]}));
        chk(32'({r.compare_en, r.settings_group}),
            32'(e[17:16]));
    endtask : chk_route

    // ==========================================================
    // Main sequence
    // ==========================================================
    initial
    begin
        void'($urandom(32'h3B30));
        {i_rst_n, i_wr, i_rd, i_res_valid, i_clk_en} = 5'h01;
        {i_addr, i_wdata, i_res_data, i_res_id, i_scan_index} = '0;
        {ovf, show, st, mask, latest, code, error_cnt, checked} = '0;
        repeat (20) @(posedge i_sys_clk);
        i_rst_n <= 1'b1;
        // Reset values, unmapped read, write to a read-only word ignored
        bus_wr(OFS_SCAN_LATEST_RESULT, 32'hFFFF_FFFF);
        foreach (codes[k])
        begin
            bus_rd(8'h80 + 8'(4 * k), rdv);
            // Empty pop at 0x84 has set its sticky bit by the 0x90 read
            chk(rdv, (k == 4) ? 32'(1 << IRQ_EMPTY_POP)
                : RST_ZERO);
        end
        bus_rd(8'h40, rdv);
        chk(rdv, RST_ZERO);
        chk_route(o_single_route, 18'h0);
        // Every alignment code, 6 and 7 acting as 0, id hidden and shown
        for (int c = 0; c < 8; c++)
            for (int s = 0; s < 2; s++)
            begin
                code = (c > 5) ? 0 : c;
                show = s[0];
                mask = 3'(c + s);
                bus_wr(OFS_IRQ_MASK, 32'(mask));
                bus_wr(OFS_SCAN_FIFO_CFG, 32'({show, 3'(c)}));
                bus_rd(OFS_SCAN_FIFO_CFG, rdv);
                chk(rdv, 32'({show, 3'(c)}));
                push(20'($urandom()), 8'($urandom()));
                chk_state();
                pop();
            end
        // Overfill, drain in order, then pop an empty FIFO
        mask = 3'h7;
        bus_wr(OFS_IRQ_MASK, 32'(mask));
        for (int k = 0; k < DEPTH + 2; k++)
        begin
            push(20'($urandom()), 8'(k));
            chk_state();
        end
        for (int k = 0; k < DEPTH + 1; k++)
        begin
            pop();
            chk_state();
        end
        bus_rd(OFS_IRQ_STATUS, rdv);
        chk(rdv, 32'(st));
        st = '0;
        chk_state();
        // Frozen clock enable ignores both pushes and pops
        push(20'h8_0001, 8'h5A);
        @(posedge i_sys_clk);
        i_clk_en <= 1'b0;
        @(posedge i_sys_clk);
        i_res_valid <= 1'b1;
        bus_rd(OFS_SCAN_FIFO_POP_DATA, rdv);
        @(posedge i_sys_clk);
        i_res_valid <= 1'b0;
        i_clk_en <= 1'b1;
        chk_state();
        pop();
        // Entry registers: upper bits written as zero, decode follows the fields
        for (int k = 0; k < 17; k++)
        begin
            ent = {2'($urandom()), codes[$urandom() % 8], 4'($urandom()),
                codes[$urandom() % 8], 4'($urandom())};
            ea = (k < 16) ? OFS_SCAN_ENTRY_BASE + 8'(4 * k)
                : OFS_SINGLE_QUEUE_SEL;
            bus_wr(ea, {14'h0000, ent});
            bus_rd(ea, rdv);
            chk(rdv, 32'(ent));
            @(posedge i_sys_clk);
            i_scan_index <= 4'(k);
            @(posedge i_sys_clk);
            #1;
            chk_route((k < 16) ? o_scan_route : o_single_route, ent);
        end
        print_verdict();
    end

endmodule : asr_scan_block_tb_top

// ---- verilog/asr_scan_block.sv ----
/*
 * Scan result FIFO readout, output word alignment and the single queue /
 * scan entry input selection registers of an incremental converter.
 * Assumes the conversion engine presents one result per pulse on the
 * same clock, and a register master that obeys one-cycle strobes.
 */
// Contract
// [RULE1] Right codes: id top, sign, data low
// [RULE2] Left codes: data top, zeros, id low
// [RULE3] Alignment code in config bits 2:0
// [RULE4] Show-identifier bit inserts entry identifier
// [RULE5] Pop-data read returns oldest, pops it
// [RULE6] Status bits 3:0 give entry count
// [RULE7] Latest-result read never pops
// [RULE8] Overflow stops FIFO, latest still updates
// [RULE9] Entry bit 17 enables window compare
// [RULE10] Entry bit 16 picks settings group
// [RULE11] Positive port field decode, bits 15:12
// [RULE12] Positive pin field, bits 11:8
// [RULE13] Negative port field decode, bits 7:4
// [RULE14] Negative pin field, bits 3:0
// [RULE15] Identical entry layout, array at base
// [RULE16] Software keeps bits 31:18 at zero
// [RULE17] Empty pop leaves count and pointers
`timescale 1ns/1ps

module asr_scan_block
    import asr_pkg::*;
#(
    parameter int DEPTH = 4,
    parameter int NUM_ENTRIES = 16
)(
    input wire logic i_sys_clk,
    input wire logic i_rst_n,
    input wire logic i_clk_en,
    input wire logic [7:0] i_addr,
    input wire logic [31:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [31:0] o_rdata,
    input wire logic i_res_valid,
    input wire logic [19:0] i_res_data,
    input wire logic [7:0] i_res_id,
    input wire logic [3:0] i_scan_index,
    output asr_route_t o_single_route,
    output asr_route_t o_scan_route,
    output logic o_fifo_overflow,
    output logic o_irq
);

    // ==========================================================
    // Elaboration checks
    // ==========================================================
    localparam int AW = $clog2(DEPTH);
    // Count field is 4 bits and pointers wrap, so depth stays a power of two
    if (DEPTH < 2 || DEPTH > 8 || (DEPTH & (DEPTH - 1)) != 0)
    begin : g_bad_depth
        $error("DEPTH must be a power of two from 2 to 8");
    end
    if (NUM_ENTRIES < 1 || NUM_ENTRIES > 16)
    begin : g_bad_entries
        $error("NUM_ENTRIES must be 1 to 16");
    end

    // ==========================================================
    // State
    // ==========================================================
    typedef struct packed {
        logic [2:0] align;
        logic show_id;
        logic [DEPTH-1:0][31:0] mem;
        logic [AW-1:0] wptr;
        logic [AW-1:0] rptr;
        logic [3:0] count;
        logic ovfl;
        logic [31:0] latest;
        logic [31:0] rdata;
        logic [IRQ_W-1:0] irq_stat;
        logic [IRQ_W-1:0] irq_mask;
        asr_entry_t single_sel;
        logic [NUM_ENTRIES-1:0][ENTRY_W-1:0] scan_sel;
    } asr_state_t;

    asr_state_t st;
    asr_state_t next_st;

    asr_bus_t bus;
    asr_result_t res;
    assign bus = '{addr: i_addr, wdata: i_wdata, wr: i_wr, rd: i_rd};
    assign res = '{data: i_res_data, id: i_res_id};

    // ==========================================================
    // Output word formatting
    // ==========================================================
    logic [7:0] shown_id;
    logic [31:0] word;
    always_comb
    begin
        shown_id = st.show_id ? res.id : SHOWN_ID_NONE; // [RULE4]
        case (asr_align_t'(st.align)) // [RULE3]
            right_justify_12bit:
                word = {shown_id, {12{res.data[11]}}, res.data[11:0]};
            right_justify_16bit:
                word = {shown_id, {8{res.data[15]}}, res.data[15:0]};
            right_justify_20bit: // [RULE1]
                word = {shown_id, {4{res.data[19]}}, res.data[19:0]};
            left_justify_12bit:
                word = {res.data[11:0], 12'h000, shown_id};
            left_justify_16bit:
                word = {res.data[15:0], 8'h00, shown_id};
            left_justify_20bit: // [RULE2]
                word = {res.data[19:0], 4'h0, shown_id};
            default:
                word = {shown_id, {12{res.data[11]}}, res.data[11:0]};
        endcase
    end

    // ==========================================================
    // Entry decode toward the analog multiplexer
    // ==========================================================
    function automatic asr_route_t decode(input asr_entry_t e);
        asr_route_t r;
        r = '0;
        r.compare_en = e.window_compare_enable; // [RULE9]
        r.settings_group = e.settings_group_sel; // [RULE10]
        r.pos_ground = (e.positive_port_select == PORT_GND); // [RULE11]
        r.pos_supply = (e.positive_port_select == PORT_SUPPLY);
        r.pos_conv_ch = (e.positive_port_select == PORT_CONV_CH);
        r.pos_pad = (e.positive_port_select == PORT_ANALOG_PAD);
        r.pos_io = (e.positive_port_select >= PORT_IO_FIRST) &&
                   (e.positive_port_select <= PORT_IO_LAST);
        r.pos_io_port = e.positive_port_select[1:0];
        r.pos_pin = e.positive_pin_select; // [RULE12]
        r.neg_ground = (e.negative_port_select == PORT_GND); // [RULE13]
        r.neg_conv_ch = (e.negative_port_select == PORT_CONV_CH);
        r.neg_pad = (e.negative_port_select == PORT_ANALOG_PAD);
        r.neg_io = (e.negative_port_select >= PORT_IO_FIRST) &&
                   (e.negative_port_select <= PORT_IO_LAST);
        r.neg_io_port = e.negative_port_select[1:0];
        r.neg_pin = e.negative_pin_select; // [RULE14]
        return r;
    endfunction : decode

    logic [3:0] scan_idx;
    always_comb
    begin
        // Compared as int: a 4-bit copy of 16 would wrap to zero
        scan_idx = (int'(i_scan_index) < NUM_ENTRIES) ? i_scan_index : 4'h0;
    end

    // ==========================================================
    // Address decode for the scan entry array
    // ==========================================================
    logic entry_hit;
    logic [3:0] entry_idx;
    logic [7:0] entry_ofs;
    always_comb
    begin
        entry_ofs = bus.addr - OFS_SCAN_ENTRY_BASE; // [RULE15]
        entry_idx = entry_ofs[5:2];
        entry_hit = (bus.addr >= OFS_SCAN_ENTRY_BASE) &&
                    (entry_ofs[7:6] == 2'b00) && (entry_ofs[1:0] == 2'b00) &&
                    (int'(entry_idx) < NUM_ENTRIES);
    end

    // ==========================================================
    // Next state
    // ==========================================================
    logic push;
    logic pop;
    logic empty_pop;
    logic [IRQ_W-1:0] ev;
    always_comb
    begin
        next_st = st;
        // Overflowed FIFO takes no new words until drained below full
        push = i_res_valid && !st.ovfl && (st.count != 4'(DEPTH)); // [RULE8]
        pop = bus.rd && (bus.addr == OFS_SCAN_FIFO_POP_DATA) &&
              (st.count != 4'h0); // [RULE5]
        empty_pop = bus.rd && (bus.addr == OFS_SCAN_FIFO_POP_DATA) &&
                    (st.count == 4'h0); // [RULE17]
        ev = '0;
        ev[IRQ_PUSH] = push;
        ev[IRQ_OVFL] = i_res_valid && !push;
        ev[IRQ_EMPTY_POP] = empty_pop;

        if (i_res_valid)
            next_st.latest = word; // [RULE8]
        if (push)
        begin
            next_st.mem[st.wptr] = word;
            next_st.wptr = st.wptr + AW'(1);
        end
        if (pop)
            next_st.rptr = st.rptr + AW'(1); // [RULE5]
        next_st.count = st.count + {3'h0, push} - {3'h0, pop}; // [RULE6]
        if (i_res_valid && !push)
            next_st.ovfl = 1'b1;
        else if (pop)
            next_st.ovfl = 1'b0;

        // Read data, registered for the cycle after the strobe
        next_st.rdata = 32'h0000_0000;
        if (bus.rd)
        begin
            case (bus.addr)
                OFS_SCAN_FIFO_CFG:
                    next_st.rdata = {28'h0, st.show_id, st.align};
                OFS_SCAN_FIFO_POP_DATA:
                    next_st.rdata = (st.count != 4'h0) ?
                                    st.mem[st.rptr] : 32'h0000_0000;
                OFS_SCAN_FIFO_STATUS:
                    next_st.rdata = {28'h0, st.count}; // [RULE6]
                OFS_SCAN_LATEST_RESULT:
                    next_st.rdata = st.latest; // [RULE7]
                OFS_IRQ_STATUS:
                    next_st.rdata = {29'h0, st.irq_stat};
                OFS_IRQ_MASK:
                    next_st.rdata = {29'h0, st.irq_mask};
                OFS_SINGLE_QUEUE_SEL:
                    next_st.rdata = {14'h0, st.single_sel};
                default:
                    if (entry_hit)
                        next_st.rdata = {14'h0, st.scan_sel[entry_idx]};
            endcase
        end

        // Sticky status: a read clears, but a same-cycle event wins
        if (bus.rd && bus.addr == OFS_IRQ_STATUS)
            next_st.irq_stat = ev;
        else
            next_st.irq_stat = st.irq_stat | ev;

        // Writes; upper entry bits are dropped
        if (bus.wr)
        begin
            case (bus.addr)
                OFS_SCAN_FIFO_CFG:
                begin
                    next_st.align = bus.wdata[ALIGN_LSB +: 3]; // [RULE3]
                    next_st.show_id = bus.wdata[SHOW_ENTRY_IDENTIFIER_BIT]; // [RULE4]
                end
                OFS_IRQ_MASK:
                    next_st.irq_mask = bus.wdata[IRQ_W-1:0];
                OFS_SINGLE_QUEUE_SEL:
                    next_st.single_sel = bus.wdata[ENTRY_W-1:0]; // [RULE15]
                default:
                    if (entry_hit)
                        next_st.scan_sel[entry_idx] =
                            bus.wdata[ENTRY_W-1:0]; // [RULE15]
            endcase
        end
    end

    // ==========================================================
    // State register
    // ==========================================================
    always_ff @(posedge i_sys_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
            st <= '0;
        else if (i_clk_en)
            st <= next_st;
    end

    // Outputs
    assign o_rdata = st.rdata;
    assign o_single_route = decode(st.single_sel);
    assign o_scan_route = decode(asr_entry_t'(st.scan_sel[scan_idx]));
    assign o_fifo_overflow = st.ovfl;
    assign o_irq = |(st.irq_stat & st.irq_mask);

    // ==========================================================
    // Assertions
    // ==========================================================
    default clocking cb @(posedge i_sys_clk);
    endclocking
    default disable iff (!i_rst_n);

    property p_right_justify_20bit;
        i_clk_en && i_res_valid && st.align == 3'h2 && st.show_id
        |=> st.latest == {$past(i_res_id), {4{$past(i_res_data[19])}},
                          $past(i_res_data)};
    endproperty
    a_right_justify_20bit: assert property (p_right_justify_20bit) // [RULE1]
        else $error("right 20 word wrong");

    property p_left_justify_12bit;
        i_clk_en && i_res_valid && st.align == 3'h3 && !st.show_id
        |=> st.latest == {$past(i_res_data[11:0]), 20'h00000};
    endproperty
    a_left_justify_12bit: assert property (p_left_justify_12bit) // [RULE2]
        else $error("left 12 word wrong");

    property p_cfg;
        i_clk_en && i_wr && i_addr == OFS_SCAN_FIFO_CFG
        |=> st.align == $past(i_wdata[2:0]) &&
            st.show_id == $past(i_wdata[3]);
    endproperty
    a_cfg: assert property (p_cfg) // [RULE3]
        else $error("config not stored");

    property p_noid;
        i_clk_en && i_res_valid && !st.show_id && st.align == 3'h0
        |=> st.latest[31:24] == 8'h00;
    endproperty
    a_noid: assert property (p_noid) // [RULE4]
        else $error("identifier shown while hidden");

    property p_pop;
        i_clk_en && i_rd && i_addr == OFS_SCAN_FIFO_POP_DATA &&
        st.count != 4'h0 && !i_res_valid
        |=> st.count == $past(st.count) - 4'h1 &&
            o_rdata == $past(st.mem[st.rptr]);
    endproperty
    a_pop: assert property (p_pop) // [RULE5]
        else $error("pop failed");

    property p_stat;
        i_clk_en && i_rd && i_addr == OFS_SCAN_FIFO_STATUS
        |=> o_rdata == {28'h0, $past(st.count)};
    endproperty
    a_stat: assert property (p_stat) // [RULE6]
        else $error("status count wrong");

    property p_latest;
        i_clk_en && i_rd && i_addr == OFS_SCAN_LATEST_RESULT && !i_res_valid
        |=> st.count == $past(st.count) && o_rdata == $past(st.latest);
    endproperty
    a_latest: assert property (p_latest) // [RULE7]
        else $error("latest read disturbed fifo");

    property p_ovfl;
        i_clk_en && st.ovfl && i_res_valid && !i_rd
        |=> st.count == $past(st.count) && st.wptr == $past(st.wptr);
    endproperty
    a_ovfl: assert property (p_ovfl) // [RULE8]
        else $error("fifo accepted after overflow");

    property p_empty;
        i_clk_en && i_rd && i_addr == OFS_SCAN_FIFO_POP_DATA &&
        st.count == 4'h0 && !i_res_valid
        |=> st.count == 4'h0 && st.rptr == $past(st.rptr);
    endproperty
    a_empty: assert property (p_empty) // [RULE17]
        else $error("empty pop moved pointers");

    c_fill: cover property (st.count == 4'(DEPTH));
    c_ovfl: cover property (i_clk_en && st.ovfl && i_res_valid);
    c_pop: cover property (i_clk_en && i_rd &&
                           i_addr == OFS_SCAN_FIFO_POP_DATA &&
                           st.count != 4'h0);
    c_irq: cover property (o_irq);

endmodule : asr_scan_block
